// *** logic/sbs_pkg.sv ***
// shared constants for the memory boundary-scan test port
// assumes a standard four-pin serial test controller outside the device
package sbs_pkg;
  localparam int IR_WIDTH      = 3;
  localparam int ID_WIDTH      = 32;
  localparam int BSR_CELLS     = 107;
  localparam int INTERNAL_CELL = 48;   // not used; the cell with no pin behind it is 47
  localparam int RESET_TMS_EDGES = 5;
  // instruction codes, 3 bits
  localparam logic [2:0] INS_EXTEST  = 3'h0;
  localparam logic [2:0] INS_IDCODE  = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE  = 3'h4;
  localparam logic [2:0] INS_BYPASS  = 3'h7;
  localparam logic [2:0] IR_RESET    = INS_IDCODE;
  // id code field layout
  localparam int ID_REV_LSB  = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_VEND_LSB = 1;
  // controller states
  typedef enum logic [3:0] {
    SBS_RESET, SBS_IDLE, SBS_SELDR, SBS_CAPDR, SBS_SHDR, SBS_EX1DR,
    SBS_PSDR, SBS_EX2DR, SBS_UPDR, SBS_SELIR, SBS_CAPIR, SBS_SHIR,
    SBS_EX1IR, SBS_PSIR, SBS_EX2IR, SBS_UPIR
  } sbs_state_e;
endpackage : sbs_pkg

// *** logic/sbs_sync.sv ***
// two-flop synchroniser for a bus of levels
// assumes the input changes slowly compared with the destination clock
`timescale 1ns/1ps
`default_nettype none
module sbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] dout_d;

  // first stage feeds only the second
  always_comb
  begin
    meta_d = din;
    dout_d = meta_q;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      dout   <= dout_d;
    end
  end
endmodule : sbs_sync
`default_nettype wire

// *** logic/sbs_tap.sv ***
// boundary-scan test port of the memory: controller, ir, bypass, id, bsr
// assumes tck from the test controller; pins arrive on the memory clock
`timescale 1ns/1ps
`default_nettype none
module sbs_tap #(
  parameter logic [3:0]  ID_REV  = 4'h0,     // arbitrary value
  parameter logic [15:0] ID_PART = 16'h1234, // arbitrary value
  parameter logic [10:0] ID_VEND = 11'h2a5   // arbitrary value
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         tck,
  input  wire logic         tms,
  input  wire logic         tdi,
  output var  logic         tdo,
  output var  logic         tdoOen,
  input  wire logic [105:0] pinState,
  output var  logic [2:0]   curInstr,
  output var  logic         outputsOff
);
  localparam logic [31:0] ID_CODE = {ID_REV, ID_PART, ID_VEND, 1'b1};

  sbs_pkg::sbs_state_e st_q, st_d;
  logic [2:0]   ir_q, ir_d, irSh_q, irSh_d;
  logic         byp_q, byp_d;
  logic [31:0]  id_q, id_d;
  logic [106:0] bsr_q, bsr_d;
  logic         tdo_d, tdoOen_d;
  logic         tdoN_q, tdoOenN_q;
  logic [105:0] pinSync;
  logic [2:0]   insSyncX;     // synced copy, xor-coded so reset reads idcode
  logic [2:0]   insSeen;
  logic [2:0]   insPrev_q, insPrev_d;
  logic [2:0]   curInstr_d;
  logic         outputsOff_d;

  // pins come from the memory clock domain; keeps them steady
  sbs_sync #(.W(106)) uPins (
    .clk  (tck),
    .rstn (rstn),
    .din  (pinState),
    .dout (pinSync)
  );

  // data register selection per instruction
  function automatic logic selBsr(input logic [2:0] ins);
    selBsr = (ins == sbs_pkg::INS_EXTEST) || (ins == sbs_pkg::INS_SAMPLE)
          || (ins == sbs_pkg::INS_SAMPLEZ);
  endfunction : selBsr

  // controller next state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      sbs_pkg::SBS_RESET: st_d = tms ? sbs_pkg::SBS_RESET : sbs_pkg::SBS_IDLE;
      sbs_pkg::SBS_IDLE:  st_d = tms ? sbs_pkg::SBS_SELDR : sbs_pkg::SBS_IDLE;
      sbs_pkg::SBS_SELDR: st_d = tms ? sbs_pkg::SBS_SELIR : sbs_pkg::SBS_CAPDR;
      sbs_pkg::SBS_CAPDR: st_d = tms ? sbs_pkg::SBS_EX1DR : sbs_pkg::SBS_SHDR;
      sbs_pkg::SBS_SHDR:  st_d = tms ? sbs_pkg::SBS_EX1DR : sbs_pkg::SBS_SHDR;
      sbs_pkg::SBS_EX1DR: st_d = tms ? sbs_pkg::SBS_UPDR  : sbs_pkg::SBS_PSDR;
      sbs_pkg::SBS_PSDR:  st_d = tms ? sbs_pkg::SBS_EX2DR : sbs_pkg::SBS_PSDR;
      sbs_pkg::SBS_EX2DR: st_d = tms ? sbs_pkg::SBS_UPDR  : sbs_pkg::SBS_SHDR;
      sbs_pkg::SBS_UPDR:  st_d = tms ? sbs_pkg::SBS_SELDR : sbs_pkg::SBS_IDLE;
      sbs_pkg::SBS_SELIR: st_d = tms ? sbs_pkg::SBS_RESET : sbs_pkg::SBS_CAPIR;
      sbs_pkg::SBS_CAPIR: st_d = tms ? sbs_pkg::SBS_EX1IR : sbs_pkg::SBS_SHIR;
      sbs_pkg::SBS_SHIR:  st_d = tms ? sbs_pkg::SBS_EX1IR : sbs_pkg::SBS_SHIR;
      sbs_pkg::SBS_EX1IR: st_d = tms ? sbs_pkg::SBS_UPIR  : sbs_pkg::SBS_PSIR;
      sbs_pkg::SBS_PSIR:  st_d = tms ? sbs_pkg::SBS_EX2IR : sbs_pkg::SBS_PSIR;
      sbs_pkg::SBS_EX2IR: st_d = tms ? sbs_pkg::SBS_UPIR  : sbs_pkg::SBS_SHIR;
      sbs_pkg::SBS_UPIR:  st_d = tms ? sbs_pkg::SBS_SELDR : sbs_pkg::SBS_IDLE;
    endcase
  end
  // graph guarantees reset within five tms-high edges from any state

  // register actions on rising tck
  always_comb
  begin
    ir_d   = ir_q;
    irSh_d = irSh_q;
    byp_d  = byp_q;
    id_d   = id_q;
    bsr_d  = bsr_q;
    unique case (st_q)
      sbs_pkg::SBS_RESET: ir_d = sbs_pkg::IR_RESET;
      sbs_pkg::SBS_CAPIR: irSh_d = 3'h1;            // standard 01 capture
      sbs_pkg::SBS_SHIR:  irSh_d = {tdi, irSh_q[2:1]};
      sbs_pkg::SBS_UPIR:  ir_d = irSh_q;
      sbs_pkg::SBS_CAPDR:
      begin
        byp_d = 1'b0;
        if (ir_q == sbs_pkg::INS_IDCODE)
          id_d = ID_CODE;
        if (selBsr(ir_q))
          // cell 47 has no pin; captures zero
          bsr_d = {pinSync[105:47], 1'b0, pinSync[46:0]};
      end
      sbs_pkg::SBS_SHDR:
      begin
        if (ir_q == sbs_pkg::INS_IDCODE)
          id_d = {tdi, id_q[31:1]};
        else if (selBsr(ir_q))
          bsr_d = {tdi, bsr_q[106:1]};
        else
          byp_d = tdi;
      end
      default: ;
    endcase
  end

  // serial output value chosen by state and instruction
  always_comb
  begin
    tdoOen_d = 1'b1;
    tdo_d    = 1'b0;
    if (st_q == sbs_pkg::SBS_SHIR)
    begin
      tdoOen_d = 1'b0;
      tdo_d    = irSh_q[0];
    end
    else if (st_q == sbs_pkg::SBS_SHDR)
    begin
      tdoOen_d = 1'b0;
      if (ir_q == sbs_pkg::INS_IDCODE)
        tdo_d = id_q[0];
      else if (selBsr(ir_q))
        tdo_d = bsr_q[0];
      else
        tdo_d = byp_q;
    end
  end

  // rising-edge state; power-up reset via rstn
  always_ff @(posedge tck or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q   <= sbs_pkg::SBS_RESET;
      ir_q   <= sbs_pkg::IR_RESET;
      irSh_q <= '0;
      byp_q  <= 1'b0;
      id_q   <= '0;
      bsr_q  <= '0;
    end
    else
    begin
      st_q   <= st_d;
      ir_q   <= ir_d;
      irSh_q <= irSh_d;
      byp_q  <= byp_d;
      id_q   <= id_d;
      bsr_q  <= bsr_d;
    end
  end

  // tdo retimed on falling edge so the far end samples mid-bit
  always_ff @(negedge tck or negedge rstn)
  begin
    if (!rstn)
    begin
      tdoN_q    <= 1'b0;
      tdoOenN_q <= 1'b1;
    end
    else
    begin
      tdoN_q    <= tdo_d;
      tdoOenN_q <= tdoOen_d;
    end
  end

  always_comb
  begin
    tdo    = tdoN_q;
    tdoOen = tdoOenN_q;
  end

  // instruction handed to the memory clock domain; slow, so two flops
  // xor with the reset code keeps the synchroniser's zero reset glitch-free
  sbs_sync #(.W(3)) uIns (
    .clk  (clk),
    .rstn (rstn),
    .din  (ir_q ^ sbs_pkg::IR_RESET),
    .dout (insSyncX)
  );

  // a word is taken only once two samples agree, so bits that
  // cross with skew never show up as a false instruction
  always_comb
  begin
    insSeen      = insSyncX ^ sbs_pkg::IR_RESET;
    insPrev_d    = insSeen;
    curInstr_d   = curInstr;
    if (insSeen == insPrev_q)
      curInstr_d = insSeen;
    outputsOff_d = (curInstr_d == sbs_pkg::INS_SAMPLEZ);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      curInstr   <= sbs_pkg::IR_RESET;
      outputsOff <= 1'b0;
      insPrev_q  <= sbs_pkg::IR_RESET;
    end
    else
    begin
      curInstr   <= curInstr_d;
      outputsOff <= outputsOff_d;
      insPrev_q  <= insPrev_d;
    end
  end
endmodule : sbs_tap
`default_nettype wire

// *** tb/sbs_ctl_model.sv ***
// test controller model: owns tck, tms and tdi
// assumes one caller at a time; tck is still between calls
`timescale 1ns/1ps
`default_nettype none
module sbs_ctl_model (
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 12 ns period; tdo taken just as tck rises
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #6 o = tdo;
    tck = 1'b1;
    #6 tck = 1'b0;
  endtask : step
  // no reset pin, so five tms-high edges, then park in idle
  task automatic reset;
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : reset
  // idle to shift-IR or shift-DR, n bits lsb first, back to idle
  task automatic scan(input logic isIr, input int n,
                      input logic [127:0] din, output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (isIr)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : scan
endmodule : sbs_ctl_model
`default_nettype wire

// *** tb/sbs_tap_sva.sv ***
// assertions on the test port pins, tck domain
// assumes tck stands still between controller frames
`timescale 1ns/1ps
`default_nettype none
module sbs_tap_sva #(
  parameter logic [3:0]  ID_REV  = 4'h0,
  parameter logic [15:0] ID_PART = 16'h0,
  parameter logic [10:0] ID_VEND = 11'h0
) (
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         tck,
  input wire logic         tms,
  input wire logic         tdi,
  input wire logic         tdo,
  input wire logic         tdoOen,
  input wire logic [105:0] pinState,
  input wire logic [2:0]   curInstr,
  input wire logic         outputsOff
);
  default clocking cb @(posedge tck);
  endclocking
  default disable iff (!rstn);
  // reset, idle, then straight into a shift state
  sequence sReset;
    tms [*5];
  endsequence
  sequence sIdShift;
    sReset ##1 !tms ##1 tms ##1 !tms [*2];
  endsequence
  sequence sIrShift;
    sReset ##1 !tms ##1 tms [*2] ##1 !tms [*2];
  endsequence
  AST_RESET5: assert property (sReset |-> ##5 curInstr == 3'h1)
    else $error("instruction not idcode after tms reset");
  AST_OEN_IDLE: assert property (sReset |-> ##1 tdoOen)
    else $error("tdo driven outside shift");
  AST_OEN_SHIFT: assert property (sIdShift |-> ##2 !tdoOen)
    else $error("tdo not driven in shift-DR");
  AST_ID_BIT0: assert property (sIdShift |-> ##1 tdo)
    else $error("id bit 0 not one");
  AST_ID_VEND: assert property (sIdShift |-> ##2 tdo == ID_VEND[0])
    else $error("id vendor field lsb wrong");
  AST_ID_PART: assert property (sIdShift |-> ##13 tdo == ID_PART[0])
    else $error("id part field lsb wrong");
  AST_ID_REV: assert property (sIdShift |-> ##32 tdo == ID_REV[3])
    else $error("id revision msb wrong");
  AST_IR_CAP: assert property (sIrShift |-> ##1 tdo ##1 !tdo)
    else $error("ir capture pattern wrong");
endmodule : sbs_tap_sva
bind sbs_tap sbs_tap_sva #(.ID_REV(ID_REV), .ID_PART(ID_PART),
  .ID_VEND(ID_VEND)) chk (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdoOen(tdoOen), .pinState(pinState),
  .curInstr(curInstr), .outputsOff(outputsOff));
`default_nettype wire

// *** tb/sbs_tap_test.sv ***
// self-checking bench of the memory test port
// assumes the controller model owns tck, tms and tdi
`timescale 1ns/1ps
`default_nettype none
module sbs_tap_test;
  localparam logic [3:0]  REV  = 4'ha;     // arbitrary value
  localparam logic [15:0] PART = 16'h0f35; // arbitrary value
  localparam logic [10:0] VEND = 11'h2c3;  // arbitrary value
  logic         clk, rstn, tck, tms, tdi, tdo, tdoOen, outputsOff;
  logic [105:0] pinState;
  logic [2:0]   curInstr;
  logic [127:0] got;
  int           errors, tests_run;
  sbs_tap #(.ID_REV(REV), .ID_PART(PART), .ID_VEND(VEND)) dut (
    .clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOen(tdoOen), .pinState(pinState), .curInstr(curInstr),
    .outputsOff(outputsOff));
  sbs_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [127:0] exp,
                       input logic [127:0] act);
    tests_run++;
    if (act !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, act);
    end
  endtask : check
  task automatic test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // idcode chosen at power-up, shifted out whole
  task automatic t_id;
    check("curInstr", 128'(sbs_pkg::INS_IDCODE), 128'(curInstr));
    ctl.scan(1'b0, 32, '0, got);
    check("idcode", 128'({REV, PART, VEND, 1'b1}), got);
  endtask : t_id
  // bypass and an unlisted code both give a one-stage path
  task automatic t_bypass;
    logic [2:0] codes [2] = '{sbs_pkg::INS_BYPASS, 3'h3};
    foreach (codes[k])
    begin
      ctl.scan(1'b1, 3, 128'(codes[k]), got);
      check("irCapture", 128'h1, got);
      repeat (6) @(negedge clk);
      check("curInstr", 128'(codes[k]), 128'(curInstr));
      ctl.scan(1'b0, 5, 128'h0d, got);
      check("bypass", 128'h1a, got);
    end
  endtask : t_bypass
  // every instruction that picks the boundary register; cell 47 has no pin
  task automatic t_bsr;
    logic [2:0] codes [3] = '{sbs_pkg::INS_SAMPLE, sbs_pkg::INS_SAMPLEZ,
                              sbs_pkg::INS_EXTEST};
    foreach (codes[k])
    begin
      @(negedge clk) pinState = ~{pinState[104:0], pinState[105]};
      ctl.scan(1'b1, 3, 128'(codes[k]), got);
      repeat (6) @(negedge clk);
      check("outputsOff", 128'(codes[k] == sbs_pkg::INS_SAMPLEZ),
            128'(outputsOff));
      ctl.scan(1'b0, 107, '0, got);
      check("bsr", 128'({pinState[105:47], 1'b0, pinState[46:0]}),
            got);
    end
  endtask : t_bsr
  // tms reset from a loaded bypass brings idcode back
  task automatic t_reset;
    ctl.reset();
    ctl.scan(1'b1, 3, 128'(sbs_pkg::INS_BYPASS), got);
    ctl.reset();
    repeat (6) @(negedge clk);
    t_id();
  endtask : t_reset
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    pinState = 106'h3c5a_f00f_6996_a55a_c33c_1e;
    errors = 0;
    tests_run = 0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    ctl.reset();
    t_id();
    t_bypass();
    t_bsr();
    t_reset();
    test_done();
  end
  // whole run is near 500 tck steps; far more means a hang
  initial
  begin
    #200000;
    errors++;
    test_done();
  end
endmodule : sbs_tap_test
`default_nettype wire
